// [sdsp_ctrl.sv]
// strap decode, database selection, recorder stream extras and front panel
module sdsp_ctrl #(
   parameter int unsigned TICK_CYCLES = sdsp_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [sdsp_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [sdsp_pkg::TYPE_W-1:0] strap_type_n,
   input wire logic [sdsp_pkg::FLEET_W-1:0] strap_fleet_n,
   input wire logic [sdsp_pkg::ACNUM_W-1:0] strap_acnum_n,
   input wire logic recorder_wiring_n,
   input wire logic switch_left,
   input wire logic switch_right,
   input wire logic recorder_fault_in,
   input wire logic frame_strobe,
   output logic [sdsp_pkg::FRAME_W-1:0] stream_frame_count,
   output logic [sdsp_pkg::ACNUM_W-1:0] stream_aircraft_number,
   output logic [sdsp_pkg::BITE_W-1:0] stream_selftest_word,
   output logic [sdsp_pkg::SLOT_W-1:0] active_slot,
   output logic acq_fault_led,
   output logic rec_fault_led,
   output logic [sdsp_pkg::DISP_LEN*sdsp_pkg::CHAR_W-1:0] display_chars,
   input wire logic test_conn_rx,
   input wire logic recorder_rx,
   output logic recorder_tx,
   output logic test_conn_tx
);
   localparam int STRAP_W = sdsp_pkg::TYPE_W + sdsp_pkg::FLEET_W + sdsp_pkg::ACNUM_W + 1;

   logic ms_tick;
   logic [STRAP_W-1:0] strap_clean_n;
   logic [1:0] switch_clean;

   sdsp_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .reset(reset),
      .tick(ms_tick)
   );

   sdsp_debounce #(.W(STRAP_W)) u_strap_db (
      .clk(clk),
      .reset(reset),
      .tick(ms_tick),
      .din({recorder_wiring_n, strap_acnum_n, strap_fleet_n, strap_type_n}),
      .dout(strap_clean_n)
   );

   sdsp_debounce #(.W(2)) u_switch_db (
      .clk(clk),
      .reset(reset),
      .tick(ms_tick),
      .din({switch_left, switch_right}),
      .dout(switch_clean)
   );

   // a linked strap pulls its pin low
   wire [sdsp_pkg::TYPE_W-1:0] strap_type = ~strap_clean_n[sdsp_pkg::TYPE_W-1:0];
   wire [sdsp_pkg::FLEET_W-1:0] strap_fleet =
      ~strap_clean_n[sdsp_pkg::TYPE_W +: sdsp_pkg::FLEET_W];
   wire [sdsp_pkg::ACNUM_W-1:0] strap_acnum =
      ~strap_clean_n[sdsp_pkg::TYPE_W + sdsp_pkg::FLEET_W +: sdsp_pkg::ACNUM_W];
   wire wiring_fitted = ~strap_clean_n[STRAP_W-1];

   // software-loaded state
   logic [15:0] slot_table [sdsp_pkg::SLOTS];
   logic [sdsp_pkg::CHAR_W-1:0] text_buf [sdsp_pkg::TEXT_LEN];
   logic [sdsp_pkg::BITE_W-1:0] selftest_code;
   logic [sdsp_pkg::SLOT_W-1:0] default_slot;
   logic [sdsp_pkg::BC_SLOTS-1:0] bc_valid;

   // bus decode
   wire bus_req = (avs_read | avs_write) & avs_waitrequest;
   wire bus_wr = avs_write & ~avs_waitrequest;
   wire [31:0] lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wmask = avs_writedata & lane_mask;
   wire hit_slot = (avs_address[5:4] == sdsp_pkg::SEL_SLOT_TABLE);
   wire hit_text = (avs_address[5] == sdsp_pkg::SEL_TEXT);
   wire [sdsp_pkg::SLOT_W-1:0] slot_idx = avs_address[3:0];
   wire [4:0] text_idx = avs_address[4:0];
   wire start_pulse = bus_wr && avs_address == sdsp_pkg::ADDR_CTRL &&
                      wmask[sdsp_pkg::CTRL_START_BIT];

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   // database selection state
   sdsp_pkg::sdsp_sel_state_type sel_state;
   logic [sdsp_pkg::SLOT_W-1:0] scan_idx;
   logic [sdsp_pkg::MS_W-1:0] sel_ms;
   logic sel_done;
   logic no_match;
   logic straps_changed;
   logic [sdsp_pkg::TYPE_W-1:0] por_type;
   logic [sdsp_pkg::FLEET_W-1:0] por_fleet;

   wire [15:0] scan_entry = slot_table[scan_idx];
   wire scan_match = scan_entry[sdsp_pkg::SLOT_VALID_BIT] &&
      scan_entry[sdsp_pkg::SLOT_TYPE_LSB +: sdsp_pkg::TYPE_W] == strap_type &&
      scan_entry[sdsp_pkg::FLEET_W-1:0] == strap_fleet;
   wire scan_last = (scan_idx == sdsp_pkg::SLOT_W'(sdsp_pkg::SLOTS - 1));
   wire mon_due = ms_tick && sel_ms == sdsp_pkg::MONITOR_MS;
   wire strap_diff = (strap_type != por_type) || (strap_fleet != por_fleet);

   always_ff @(posedge clk) begin
      if (reset) begin
         sel_state <= sdsp_pkg::SEL_SETTLE;
         scan_idx <= '0;
         sel_ms <= '0;
         sel_done <= 1'b0;
         no_match <= 1'b0;
         straps_changed <= 1'b0;
         por_type <= '0;
         por_fleet <= '0;
         active_slot <= '0;
      end else begin
         case (sel_state)
            sdsp_pkg::SEL_SETTLE: begin
               if (ms_tick)
                  sel_ms <= sel_ms + 1'b1;
               if (sel_ms == sdsp_pkg::SETTLE_MS)
                  sel_state <= sdsp_pkg::SEL_IDLE;
            end
            sdsp_pkg::SEL_IDLE: begin
               scan_idx <= '0;
               sel_ms <= '0;
               if (start_pulse)
                  sel_state <= sdsp_pkg::SEL_SCAN;
            end
            sdsp_pkg::SEL_SCAN: begin
               if (scan_match || scan_last) begin
                  sel_state <= sdsp_pkg::SEL_RUN;
                  sel_done <= 1'b1;
                  no_match <= ~scan_match;
                  active_slot <= scan_match ? scan_idx : default_slot;
                  por_type <= strap_type;
                  por_fleet <= strap_fleet;
               end else
                  scan_idx <= scan_idx + 1'b1;
            end
            sdsp_pkg::SEL_RUN: begin
               if (mon_due)
                  sel_ms <= '0;
               else if (ms_tick)
                  sel_ms <= sel_ms + 1'b1;
               if (mon_due && strap_diff)
                  straps_changed <= 1'b1;
            end
            default: sel_state <= sdsp_pkg::SEL_SETTLE;
         endcase
      end
   end

   logic [sdsp_pkg::FRAME_W-1:0] frame_count;
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_count <= '0;
         stream_frame_count <= '0;
         stream_aircraft_number <= '0;
         stream_selftest_word <= '0;
      end else if (frame_strobe) begin
         frame_count <= frame_count + 1'b1;
         stream_frame_count <= frame_count;
         stream_aircraft_number <= strap_acnum;
         stream_selftest_word <= selftest_code;
      end
   end

   // straight pass-through, idle high when not fitted
   always_ff @(posedge clk) begin
      if (reset) begin
         recorder_tx <= 1'b1;
         test_conn_tx <= 1'b1;
      end else begin
         recorder_tx <= wiring_fitted ? test_conn_rx : 1'b1;
         test_conn_tx <= wiring_fitted ? recorder_rx : 1'b1;
      end
   end

   // front panel
   sdsp_pkg::sdsp_pnl_state_type pnl_state;
   logic [sdsp_pkg::PAGE_W-1:0] page;
   logic [sdsp_pkg::MS_W-1:0] lamp_ms;
   logic [sdsp_pkg::MS_W-1:0] idle_ms;
   logic [sdsp_pkg::MS_W-1:0] scroll_ms;
   logic [sdsp_pkg::POS_W-1:0] scroll_pos;
   logic [1:0] switch_prev;

   wire left_edge = switch_clean[1] & ~switch_prev[1];
   wire right_edge = switch_clean[0] & ~switch_prev[0];
   wire centred = ~|switch_clean;
   logic [sdsp_pkg::SLOTS-1:0] slot_valid;
   // a plain wire, so a table write is seen at once
   for (genvar g = 0; g < sdsp_pkg::SLOTS; g++) begin : g_slot_valid
      assign slot_valid[g] = slot_table[g][sdsp_pkg::SLOT_VALID_BIT];
   end
   wire any_loaded = (|bc_valid) || (|slot_valid);
   wire unused_page = ~any_loaded;
   wire [sdsp_pkg::PAGE_W-1:0] page_next = (page == sdsp_pkg::PAGE_LAST) ?
      sdsp_pkg::PAGE_CORE : page + 1'b1;
   wire [sdsp_pkg::PAGE_W-1:0] rec_ofs = page - sdsp_pkg::PAGE_REC_BASE;
   wire [sdsp_pkg::PAGE_W-1:0] bc_ofs = page - sdsp_pkg::PAGE_BC_BASE;
   wire is_bc_page = (page >= sdsp_pkg::PAGE_BC_BASE);
   wire is_rec_page = (page >= sdsp_pkg::PAGE_REC_BASE) && !is_bc_page;
   wire rec_loaded = slot_table[rec_ofs[sdsp_pkg::SLOT_W-1:0]][sdsp_pkg::SLOT_VALID_BIT];
   wire bc_loaded = bc_valid[bc_ofs[2:0]];
   // skip empty slots; one unused page stands in when nothing loaded
   wire page_ok = is_bc_page ? bc_loaded :
                  is_rec_page ? (rec_loaded || (unused_page && page == sdsp_pkg::PAGE_REC_BASE)) :
                  1'b1;
   wire timed_out = (idle_ms == sdsp_pkg::TIMEOUT_MS);

   always_ff @(posedge clk) begin
      if (reset) begin
         pnl_state <= sdsp_pkg::PNL_BLANK;
         page <= sdsp_pkg::PAGE_UMBRELLA;
         lamp_ms <= '0;
         switch_prev <= '0;
      end else begin
         switch_prev <= switch_clean;
         case (pnl_state)
            sdsp_pkg::PNL_BLANK: begin
               lamp_ms <= '0;
               if (left_edge || right_edge)
                  pnl_state <= sdsp_pkg::PNL_LAMP;
            end
            sdsp_pkg::PNL_LAMP: begin
               if (ms_tick)
                  lamp_ms <= lamp_ms + 1'b1;
               if (lamp_ms == sdsp_pkg::LAMP_MS) begin
                  pnl_state <= sdsp_pkg::PNL_PARTS;
                  page <= sdsp_pkg::PAGE_UMBRELLA;
               end
            end
            sdsp_pkg::PNL_PARTS: begin
               if (timed_out)
                  pnl_state <= sdsp_pkg::PNL_BLANK;
               else if (left_edge)
                  pnl_state <= sdsp_pkg::PNL_BITE;
               else if (right_edge) begin
                  pnl_state <= sdsp_pkg::PNL_SEEK;
                  page <= page_next;
               end
            end
            sdsp_pkg::PNL_SEEK: begin
               if (page_ok)
                  pnl_state <= sdsp_pkg::PNL_PARTS;
               else
                  page <= page_next;
            end
            sdsp_pkg::PNL_BITE: begin
               if (timed_out)
                  pnl_state <= sdsp_pkg::PNL_BLANK;
               else if (right_edge) begin
                  pnl_state <= sdsp_pkg::PNL_PARTS;
                  page <= sdsp_pkg::PAGE_UMBRELLA;
               end
            end
            default: pnl_state <= sdsp_pkg::PNL_BLANK;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !centred || pnl_state == sdsp_pkg::PNL_LAMP)
         idle_ms <= '0;
      else if (ms_tick && !timed_out)
         idle_ms <= idle_ms + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (reset || pnl_state != sdsp_pkg::PNL_PARTS) begin
         scroll_ms <= '0;
         scroll_pos <= '0;
      end else if (ms_tick && scroll_ms == sdsp_pkg::SCROLL_MS) begin
         scroll_ms <= '0;
         scroll_pos <= (scroll_pos == sdsp_pkg::POS_W'(sdsp_pkg::TEXT_LEN)) ?
                       '0 : scroll_pos + 1'b1;
      end else if (ms_tick)
         scroll_ms <= scroll_ms + 1'b1;
   end

   function automatic logic [sdsp_pkg::CHAR_W-1:0] hex_char(input logic [3:0] v);
      hex_char = (v < 4'hA) ? sdsp_pkg::CHAR_ZERO + {4'h0, v} : sdsp_pkg::CHAR_A_OFS + {4'h0, v};
   endfunction : hex_char

   // text followed by slash so items stay apart while wrapping
   function automatic logic [sdsp_pkg::CHAR_W-1:0] scroll_char(input logic [sdsp_pkg::POS_W:0] p);
      logic [sdsp_pkg::POS_W:0] q;
      q = (p > (sdsp_pkg::POS_W + 1)'(sdsp_pkg::TEXT_LEN)) ?
          p - (sdsp_pkg::POS_W + 1)'(sdsp_pkg::TEXT_LEN + 1) : p;
      scroll_char = (q == (sdsp_pkg::POS_W + 1)'(sdsp_pkg::TEXT_LEN)) ?
                    sdsp_pkg::CHAR_SLASH : text_buf[q[4:0]];
   endfunction : scroll_char

   wire lamp_all = (lamp_ms < sdsp_pkg::LAMP_ALL_MS);
   wire lamp_acq = !lamp_all && lamp_ms < sdsp_pkg::LAMP_ALL_MS + sdsp_pkg::LAMP_ACQ_MS;
   wire lamp_rec = !lamp_all && !lamp_acq;
   wire in_lamp = (pnl_state == sdsp_pkg::PNL_LAMP);
   wire acq_fault = no_match | straps_changed | (|selftest_code);
   logic [sdsp_pkg::DISP_LEN*sdsp_pkg::CHAR_W-1:0] next_display;

   always_comb begin
      next_display = {sdsp_pkg::DISP_LEN{sdsp_pkg::CHAR_SPACE}};
      case (pnl_state)
         sdsp_pkg::PNL_LAMP:
            if (lamp_all)
               next_display = {sdsp_pkg::DISP_LEN{sdsp_pkg::CHAR_ALL}};
         sdsp_pkg::PNL_PARTS:
            for (int i = 0; i < sdsp_pkg::DISP_LEN; i++)
               next_display[(sdsp_pkg::DISP_LEN-1-i)*sdsp_pkg::CHAR_W +: sdsp_pkg::CHAR_W] =
                  scroll_char({1'b0, scroll_pos} + (sdsp_pkg::POS_W + 1)'(i));
         sdsp_pkg::PNL_BITE:
            if (selftest_code == '0)
               next_display = sdsp_pkg::NO_FAULT_TEXT;
            else
               next_display = {sdsp_pkg::CHAR_B, sdsp_pkg::CHAR_M, hex_char(selftest_code[11:8]),
                               hex_char(selftest_code[7:4]), hex_char(selftest_code[3:0]),
                               {3{sdsp_pkg::CHAR_SPACE}}};
         default: next_display = {sdsp_pkg::DISP_LEN{sdsp_pkg::CHAR_SPACE}};
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         display_chars <= {sdsp_pkg::DISP_LEN{sdsp_pkg::CHAR_SPACE}};
         acq_fault_led <= 1'b0;
         rec_fault_led <= 1'b0;
      end else begin
         display_chars <= next_display;
         acq_fault_led <= in_lamp ? lamp_acq : acq_fault;
         rec_fault_led <= in_lamp ? lamp_rec : recorder_fault_in;
      end
   end

   // register file
   wire [31:0] status_word = {4'h0, strap_acnum, 1'b0, strap_fleet, strap_type,
                              active_slot, 1'b0, straps_changed, no_match, sel_done};
   wire [31:0] panel_word = {23'h0, unused_page, pnl_state, page};
   wire [31:0] rd_value =
      hit_text ? {24'h0, text_buf[text_idx]} :
      hit_slot ? {16'h0, slot_table[slot_idx]} :
      (avs_address == sdsp_pkg::ADDR_STATUS) ? status_word :
      (avs_address == sdsp_pkg::ADDR_SELFTEST) ? {20'h0, selftest_code} :
      (avs_address == sdsp_pkg::ADDR_DEFAULT) ? {28'h0, default_slot} :
      (avs_address == sdsp_pkg::ADDR_BC_VALID) ? {24'h0, bc_valid} :
      (avs_address == sdsp_pkg::ADDR_FRAME) ? {20'h0, frame_count} :
      (avs_address == sdsp_pkg::ADDR_PANEL) ? panel_word : 32'h0000_0000;
   wire [31:0] merged_selftest = merge({20'h0, selftest_code}, avs_writedata, lane_mask);
   wire [31:0] merged_default = merge({28'h0, default_slot}, avs_writedata, lane_mask);
   wire [31:0] merged_bc = merge({24'h0, bc_valid}, avs_writedata, lane_mask);
   wire [31:0] merged_slot = merge({16'h0, slot_table[slot_idx]}, avs_writedata, lane_mask);

   // one wait cycle, then a single-cycle answer
   always_ff @(posedge clk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else begin
         avs_waitrequest <= ~bus_req;
         if (bus_req && avs_read)
            avs_readdata <= rd_value;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         selftest_code <= '0;
         default_slot <= '0;
         bc_valid <= '0;
      end else if (bus_wr) begin
         if (avs_address == sdsp_pkg::ADDR_SELFTEST)
            selftest_code <= merged_selftest[sdsp_pkg::BITE_W-1:0];
         if (avs_address == sdsp_pkg::ADDR_DEFAULT)
            default_slot <= merged_default[sdsp_pkg::SLOT_W-1:0];
         if (avs_address == sdsp_pkg::ADDR_BC_VALID)
            bc_valid <= merged_bc[sdsp_pkg::BC_SLOTS-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < sdsp_pkg::SLOTS; i++)
            slot_table[i] <= '0;
         for (int i = 0; i < sdsp_pkg::TEXT_LEN; i++)
            text_buf[i] <= sdsp_pkg::CHAR_SPACE;
      end else if (bus_wr) begin
         if (hit_slot)
            slot_table[slot_idx] <= merged_slot[15:0];
         if (hit_text && avs_byteenable[0])
            text_buf[text_idx] <= avs_writedata[7:0];
      end
   end
endmodule : sdsp_ctrl

// [sdsp_ctrl_properties.sv]
// bus, frame count and pass-through properties of sdsp_ctrl
module sdsp_ctrl_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic frame_strobe,
   input wire logic [11:0] stream_frame_count,
   input wire logic test_conn_rx,
   input wire logic recorder_tx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] frames;
   logic [8:0] up;
   // up saturates once the wiring input is past its debounce
   always_ff @(posedge clk) begin
      frames <= reset ? 12'h000 : frames + {11'h000, frame_strobe};
      up <= reset ? 9'h000 : up + {8'h00, ~up[8]};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence req_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   a_bus_answer: assert property (req_s |=> !avs_waitrequest) else $error("late answer");
   a_answer_short: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
   a_answer_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   a_unmapped_zero: assert property (req_s and avs_read && avs_address[5:3] == 3'h1
      |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_frame_step: assert property (frame_strobe |=> stream_frame_count == frames - 12'h001)
      else $error("frame count wrong");
   a_frame_hold: assert property (!$past(reset) && !$past(frame_strobe)
      |-> $stable(stream_frame_count)) else $error("frame count moved");
   a_pass_rec: assert property (up[8] |=> recorder_tx == $past(test_conn_rx))
      else $error("pass-through wrong");
   a_reset_clear: assert property ($fell(reset)
      |-> avs_waitrequest && stream_frame_count == 12'h000) else $error("reset state");
endmodule : sdsp_ctrl_chk
bind sdsp_ctrl sdsp_ctrl_chk sdsp_ctrl_chk_i (.clk, .reset, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .frame_strobe, .stream_frame_count,
   .test_conn_rx, .recorder_tx);

// [sdsp_ctrl_tb.sv]
// self-checking bench for sdsp_ctrl
module sdsp_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, frame_strobe = 1'b0;
   logic push = 1'b0, left = 1'b0, test_conn_rx = 1'b0, recorder_rx = 1'b0, rec_fault = 1'b0;
   logic switch_left, switch_right, acq_fault_led, rec_fault_led, avs_waitrequest;
   logic [5:0] avs_address = 6'h00;
   logic [6:0] tcode = 7'h15, strap_type_n;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
   logic [11:0] stream_frame_count, stream_selftest_word;
   logic [7:0] stream_aircraft_number;
   logic [3:0] active_slot;
   logic [63:0] display_chars;
   int bad_count = 0, n_checks = 0, cyc = 0;
   sdsp_ctrl #(.TICK_CYCLES(4)) sdsp_ctrl_i (.clk, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .strap_type_n,
      .strap_fleet_n(4'h9), .strap_acnum_n(8'h5A), .recorder_wiring_n(1'b0), .switch_left,
      .switch_right, .recorder_fault_in(rec_fault), .frame_strobe, .stream_frame_count,
      .stream_aircraft_number, .stream_selftest_word, .active_slot, .acq_fault_led,
      .rec_fault_led(rec_fault_led), .display_chars, .test_conn_rx, .recorder_rx, .recorder_tx(),
      .test_conn_tx());
   sdsp_strap_model sdsp_strap_model_i (.clk, .type_code(tcode), .push, .left, .strap_type_n,
      .switch_left, .switch_right);
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      test_conn_rx <= cyc[0] ^ cyc[3];
      recorder_rx <= cyc[1];
      if (cyc == 60000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      n_checks++;
      bad_count += int'(g !== e);
      if (g !== e) $display("MISMATCH %s expected %h seen %h", n, e, g);
   endtask : chk
   task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("register", 64'(e), 64'(rdata & m));
   endtask : rd
   task automatic swing(input logic l);
      left <= l;
      push <= 1'b1;
      @(posedge clk);
      push <= 1'b0;
      repeat (400) @(posedge clk);
   endtask : swing
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      repeat (250) @(posedge clk);
      // slot 0 type mismatch, slot 2 matches
      bus(1'b1, 6'h10, 32'h8146);
      bus(1'b1, 6'h12, 32'h8156);
      bus(1'b1, 6'h03, 32'h9);
      bus(1'b1, 6'h00, 32'h1);
      repeat (40) @(posedge clk);
      rd(6'h01, 32'hFFFFFFFF, 32'h0A531521);
      rd(6'h09, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 6'h02, 32'h123);
      for (int i = 0; i < 3; i++) begin
         frame_strobe <= 1'b1;
         @(posedge clk);
         frame_strobe <= 1'b0;
         repeat (2) @(posedge clk);
         chk("frame", 64'(i), 64'(stream_frame_count));
      end
      chk("stream", 64'hA5123, 64'({stream_aircraft_number, stream_selftest_word}));
      // selection runs once per reset: a power interrupt starts it again
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk("frame reset", 64'h0, 64'(stream_frame_count));
      repeat (250) @(posedge clk);
      bus(1'b1, 6'h03, 32'h9);
      bus(1'b1, 6'h02, 32'h1A3);
      bus(1'b1, 6'h00, 32'h1);
      repeat (40) @(posedge clk);
      rd(6'h01, 32'hF3, 32'h93);
      rec_fault <= 1'b1;
      repeat (3) @(posedge clk);
      chk("leds", 64'h3, 64'({acq_fault_led, rec_fault_led}));
      swing(1'b0);
      chk("lamp", {8{8'hFF}}, display_chars);
      chk("lamp leds", 64'h0, 64'({acq_fault_led, rec_fault_led}));
      repeat (2000) @(posedge clk);
      rd(6'h06, 32'hFF, 32'h40);
      swing(1'b1);
      rd(6'h06, 32'hE0, 32'h80);
      chk("fault text", 64'h424D314133202020, display_chars);
      repeat (21000) @(posedge clk);
      rd(6'h06, 32'hE0, 32'h0);
      chk("blank", {8{8'h20}}, display_chars);
      tcode <= 7'h16;
      repeat (4500) @(posedge clk);
      rd(6'h01, 32'hF4, 32'h94);
      wrap_up();
   end
endmodule : sdsp_ctrl_tb

// [sdsp_debounce.sv]
// two-flop synchroniser and stability filter for a group of slow inputs
module sdsp_debounce #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic [W-1:0] cand;
   logic [sdsp_pkg::MS_W-1:0] stable_ms;
   wire moved = (sync != cand);

   always_ff @(posedge clk) begin
      if (reset) begin
         meta <= '0;
         sync <= '0;
         cand <= '0;
         stable_ms <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         sync <= meta;
         cand <= sync;
         if (moved)
            stable_ms <= '0;
         else if (tick && stable_ms != sdsp_pkg::DEBOUNCE_MS)
            stable_ms <= stable_ms + 1'b1;
         if (!moved && stable_ms == sdsp_pkg::DEBOUNCE_MS)
            dout <= cand;
      end
   end
endmodule : sdsp_debounce

// [sdsp_pkg.sv]
// constants and types shared by the strap/database select and panel logic
package sdsp_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int MS_W = 16;
   localparam logic [MS_W-1:0] DEBOUNCE_MS = 16'h0014;
   localparam logic [MS_W-1:0] SETTLE_MS = 16'h0032;
   localparam logic [MS_W-1:0] LAMP_MS = 16'h01F4;
   localparam logic [MS_W-1:0] LAMP_ALL_MS = 16'h012C;
   localparam logic [MS_W-1:0] LAMP_ACQ_MS = 16'h0064;
   localparam logic [MS_W-1:0] SCROLL_MS = 16'h00FA;
   localparam int MONITOR_MAX_S = 60;
   localparam logic [MS_W-1:0] MONITOR_MS = 16'h03E8;
   localparam logic [MS_W-1:0] TIMEOUT_MS = 16'h1388;

   localparam int TYPE_W = 7;
   localparam int FLEET_W = 4;
   localparam int ACNUM_W = 8;
   localparam int FRAME_W = 12;
   localparam int BITE_W = 12;
   localparam int SLOTS = 16;
   localparam int SLOT_W = 4;
   localparam int BC_SLOTS = 8;
   localparam int TEXT_LEN = 32;
   localparam int POS_W = 6;
   localparam int DISP_LEN = 8;
   localparam int CHAR_W = 8;
   localparam int ADDR_W = 6;
   localparam int PAGE_W = 5;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h01;
   localparam logic [ADDR_W-1:0] ADDR_SELFTEST = 6'h02;
   localparam logic [ADDR_W-1:0] ADDR_DEFAULT = 6'h03;
   localparam logic [ADDR_W-1:0] ADDR_BC_VALID = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_FRAME = 6'h05;
   localparam logic [ADDR_W-1:0] ADDR_PANEL = 6'h06;
   localparam logic [1:0] SEL_SLOT_TABLE = 2'h1;
   localparam logic [0:0] SEL_TEXT = 1'h1;

   localparam int SLOT_VALID_BIT = 15;
   localparam int SLOT_TYPE_LSB = 4;
   localparam int CTRL_START_BIT = 0;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_NOMATCH_BIT = 1;
   localparam int STAT_CHANGED_BIT = 2;

   localparam logic [PAGE_W-1:0] PAGE_UMBRELLA = 5'h00;
   localparam logic [PAGE_W-1:0] PAGE_CORE = 5'h01;
   localparam logic [PAGE_W-1:0] PAGE_REC_BASE = 5'h03;
   localparam logic [PAGE_W-1:0] PAGE_BC_BASE = 5'h13;
   localparam logic [PAGE_W-1:0] PAGE_LAST = 5'h1A;

   localparam logic [CHAR_W-1:0] CHAR_B = 8'h42;
   localparam logic [CHAR_W-1:0] CHAR_M = 8'h4D;
   localparam logic [CHAR_W-1:0] CHAR_SPACE = 8'h20;
   localparam logic [CHAR_W-1:0] CHAR_SLASH = 8'h2F;
   localparam logic [CHAR_W-1:0] CHAR_ALL = 8'hFF;
   localparam logic [CHAR_W-1:0] CHAR_ZERO = 8'h30;
   localparam logic [CHAR_W-1:0] CHAR_A_OFS = 8'h37;
   localparam logic [63:0] NO_FAULT_TEXT = 64'h4E4F204641554C54;

   typedef enum logic [1:0] {SEL_SETTLE, SEL_IDLE, SEL_SCAN, SEL_RUN} sdsp_sel_state_type;
   typedef enum logic [2:0] {PNL_BLANK, PNL_LAMP, PNL_PARTS, PNL_SEEK, PNL_BITE} sdsp_pnl_state_type;
endpackage : sdsp_pkg

// [sdsp_strap_model.sv]
// aircraft strap wiring and spring-return panel switch
module sdsp_strap_model (
   input wire logic clk,
   input wire logic [6:0] type_code,
   input wire logic push,
   input wire logic left,
   output logic [6:0] strap_type_n,
   output logic switch_left,
   output logic switch_right
);
   timeunit 1ns;
   timeprecision 1ps;
   int hold = 0;
   logic dir = 1'b0;
   assign strap_type_n = ~type_code;
   // momentary throw, back to centre; held past the debounce
   assign switch_left = hold > 0 && dir;
   assign switch_right = hold > 0 && !dir;
   always @(posedge clk) begin
      hold <= push ? 160 : (hold > 0 ? hold - 1 : 0);
      if (push)
         dir <= left;
   end
endmodule : sdsp_strap_model

// [sdsp_tick.sv]
// millisecond tick prescaler on the system clock
module sdsp_tick #(
   parameter int unsigned TICK_CYCLES = 40000
) (
   input wire logic clk,
   input wire logic reset,
   output logic tick
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
   logic [CW-1:0] count;
   wire at_last = (count == LAST);

   always_ff @(posedge clk) begin
      if (reset) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= at_last ? '0 : count + 1'b1;
         tick <= at_last;
      end
   end
endmodule : sdsp_tick
